// *** arpd_pkg.sv ***
// Package for the converter reset and power-down controller
package arpd_pkg;
	// Quantizer comparator pattern forced during hard reset
	localparam logic [3:0] COMP_RESET_PATTERN = 4'h3;
	// Phase-delay setting after hard reset
	localparam logic [7:0] PHASE_RESET = 8'h00;
	// Power-down field reset value and run code
	localparam logic [1:0] PD_FIELD_RESET = 2'h0;
	localparam logic [1:0] PD_FIELD_RUN = 2'h0;
	// Bit of the power-down field that joins the full-shutdown decode
	localparam int PD_FULL_BIT = 0;
	// Decimation filter settling time in ns and its cycle count at 100 MHz
	localparam int CLK_PERIOD_NS = 10;
	localparam int SETTLE_TIME_NS = 3000;
	localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Width of the conversion data word
	localparam int DATA_W = 24;

	// Power state, Gray coded along run -> settle -> down -> full
	typedef enum logic [1:0] {
		ARPD_RUN = 2'h0,
		ARPD_SETTLE = 2'h1,
		ARPD_DOWN = 2'h3,
		ARPD_FULL = 2'h2
	} arpd_state_t;

	// Configuration bits that steer the power state
	typedef struct packed {
		logic [1:0] pd_field;
		logic external_reference_select;
		logic external_clock_select;
	} arpd_cfg_t;

	// Enables sent to the analog and clock domains
	typedef struct packed {
		logic bias_en;
		logic core_clk_en;
		logic input_clk_en;
		logic vref_en;
		logic supply_mon_en;
		logic clk_prop_en;
	} arpd_power_t;
endpackage

// *** arpd_ctrl.sv ***
// Converter reset and power-down controller
//
// Overview of operation
// - Power-on reset or low reset pin in serial mode restores every register default.
// - In two-wire mode the reset pin does nothing; host uses watchdog reset.
// - Hard reset forces comparator outputs to 0011 and clears conversion data.
// - Hard reset clears the decimation filter and both output buffer stages.
// - Hard reset holds serial interface in reset; host makes no transfers.
// - Clearing power-down field re-enables bias, clock, logic; ready only after settling.
// - Shutdown entered only in serial mode via power-down field; configuration kept.
// - In shutdown output data is all zeros and no ready pulse occurs.
// - Phase-delay setting survives shutdown and applies again afterwards.
// - Shutdown gates clock from input structure and core; restored on resume.
// - Field bit 0 with both external selects gives full shutdown, all off.
// - Full shutdown only in serial mode; serial interface stays active.
// - Any of field or either select returning to zero re-enables supply monitors.
`timescale 1ns/1ns
`default_nettype none

module arpd_ctrl #(
	parameter int SETTLE_CYC = arpd_pkg::SETTLE_CYCLES
) (
	input wire logic clk_in, // Master clock
	input wire logic srst_in, // Synchronous power-on reset
	input wire logic reset_n_in, // Reset pin, active low
	input wire logic two_wire_mode_in, // High when two-wire interface is selected
	input wire logic cfg_we_in, // Configuration write strobe from serial port
	input wire arpd_pkg::arpd_cfg_t cfg_in, // Configuration write data
	input wire logic [7:0] phase_delay_in, // Phase-delay write data
	input wire logic phase_we_in, // Phase-delay write strobe
	input wire logic sample_in, // Filter produced a new sample
	input wire logic [arpd_pkg::DATA_W-1:0] sample_data_in, // New sample value
	output logic hard_reset_out, // Hard reset to whole digital side
	output logic serial_reset_out, // Holds serial interface in reset
	output logic filter_clear_out, // Clears filter and both output stages
	output logic [3:0] comp_force_out, // Forced comparator pattern
	output logic comp_force_en_out, // Comparator force enable
	output arpd_pkg::arpd_cfg_t cfg_out, // Current configuration bits
	output logic [7:0] phase_delay_out, // Held phase-delay setting
	output arpd_pkg::arpd_power_t power_out, // Power and clock enables
	output logic [arpd_pkg::DATA_W-1:0] data_out, // Output data word
	output logic sample_ready_pulse_out // One-cycle sample-ready pulse
);
	// The settle counter is 16 bits, and the ready gap needs two settle cycles
	if (SETTLE_CYC < 2 || SETTLE_CYC > 65536) begin : g_bad_settle
		$error("SETTLE_CYC must lie between 2 and 65536");
	end

	////////////////////////////////////////////////////////////////////////////
	// Reset and decode
	arpd_pkg::arpd_state_t state_reg;
	arpd_pkg::arpd_state_t state_next;
	arpd_pkg::arpd_cfg_t cfg_reg;
	logic [7:0] phase_reg;
	logic [15:0] settle_cnt_reg;
	wire logic pin_reset;
	wire logic hard_rst;
	wire logic pd_any;
	wire logic full_req;
	wire logic cfg_write_ok;
	wire logic settle_done;

	// The pin only resets in serial mode; two-wire mode relies on watchdog
	assign pin_reset = !reset_n_in && !two_wire_mode_in;
	assign hard_rst = srst_in || pin_reset;
	// Writes arrive only over serial mode, and never while in hard reset
	assign cfg_write_ok = cfg_we_in && !two_wire_mode_in && !hard_rst;
	assign pd_any = |cfg_reg.pd_field;
	assign full_req = cfg_reg.pd_field[arpd_pkg::PD_FULL_BIT]
		&& cfg_reg.external_reference_select
		&& cfg_reg.external_clock_select;
	assign settle_done = settle_cnt_reg >= 16'(SETTLE_CYC - 1);

	////////////////////////////////////////////////////////////////////////////
	// Power state machine
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			arpd_pkg::ARPD_RUN: begin
				if (full_req) state_next = arpd_pkg::ARPD_FULL;
				else if (pd_any) state_next = arpd_pkg::ARPD_DOWN;
			end
			arpd_pkg::ARPD_SETTLE: begin
				if (full_req) state_next = arpd_pkg::ARPD_FULL;
				else if (pd_any) state_next = arpd_pkg::ARPD_DOWN;
				else if (settle_done) state_next = arpd_pkg::ARPD_RUN;
			end
			arpd_pkg::ARPD_DOWN: begin
				if (full_req) state_next = arpd_pkg::ARPD_FULL;
				else if (!pd_any) state_next = arpd_pkg::ARPD_SETTLE;
			end
			arpd_pkg::ARPD_FULL: begin
				if (!full_req && pd_any) state_next = arpd_pkg::ARPD_DOWN;
				else if (!pd_any) state_next = arpd_pkg::ARPD_SETTLE;
			end
		endcase
	end

	// State, configuration and settle counter
	always_ff @(posedge clk_in) begin
		if (hard_rst) begin
			state_reg <= arpd_pkg::ARPD_RUN;
			cfg_reg <= '{arpd_pkg::PD_FIELD_RESET, 1'b0, 1'b0};
			phase_reg <= arpd_pkg::PHASE_RESET;
			settle_cnt_reg <= 16'h0000;
		end else begin
			state_reg <= state_next;
			// Configuration changes only by writes, never by shutdown itself
			if (cfg_write_ok) cfg_reg <= cfg_in;
			if (phase_we_in && !two_wire_mode_in) phase_reg <= phase_delay_in;
			if (state_reg == arpd_pkg::ARPD_SETTLE) settle_cnt_reg <= settle_cnt_reg + 16'h0001;
			else settle_cnt_reg <= 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registered outputs
	wire logic running;
	wire logic full_next;
	assign running = (state_next == arpd_pkg::ARPD_RUN);
	assign full_next = (state_next == arpd_pkg::ARPD_FULL);

	// Every output is a flop so downstream gating sees no glitches
	always_ff @(posedge clk_in) begin
		hard_reset_out <= hard_rst;
		serial_reset_out <= hard_rst;
		filter_clear_out <= hard_rst || !running;
		comp_force_en_out <= hard_rst;
		comp_force_out <= arpd_pkg::COMP_RESET_PATTERN;
		cfg_out <= cfg_reg;
		phase_delay_out <= phase_reg;
		if (hard_rst) begin
			power_out <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
			data_out <= '0;
			sample_ready_pulse_out <= 1'b0;
		end else begin
			// Bias and core clock return on leaving shutdown, during settling too
			power_out.bias_en <= !pd_any;
			power_out.core_clk_en <= !pd_any;
			power_out.input_clk_en <= !pd_any;
			power_out.vref_en <= !full_next;
			power_out.supply_mon_en <= !full_req;
			power_out.clk_prop_en <= !full_req;
			// Data flushed outside run; no ready until filter has settled
			if (!running) data_out <= '0;
			else if (sample_in) data_out <= sample_data_in;
			sample_ready_pulse_out <= running && sample_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_exit_down;
		!$past(pd_any) ##0 $past(state_reg == arpd_pkg::ARPD_DOWN);
	endsequence

	AST_RESET_CLEARS: assert property (@(posedge clk_in)
		hard_rst |=> hard_reset_out && data_out == '0 && !sample_ready_pulse_out)
		else $error("hard reset did not clear outputs");
	AST_TWO_WIRE_PIN: assert property (@(posedge clk_in) disable iff (srst_in)
		two_wire_mode_in |=> !hard_reset_out && !serial_reset_out)
		else $error("reset pin acted in two-wire mode");
	AST_COMP_FORCE: assert property (@(posedge clk_in)
		hard_rst |=> comp_force_en_out && comp_force_out == arpd_pkg::COMP_RESET_PATTERN)
		else $error("comparators not forced to reset pattern");
	AST_FILTER_CLEAR: assert property (@(posedge clk_in)
		hard_rst |=> filter_clear_out)
		else $error("filter not cleared in hard reset");
	AST_SERIAL_HELD: assert property (@(posedge clk_in)
		hard_rst |=> serial_reset_out && cfg_reg.pd_field == arpd_pkg::PD_FIELD_RESET
			&& !cfg_reg.external_reference_select && !cfg_reg.external_clock_select)
		else $error("serial side active in hard reset");
	AST_SETTLE_GAP: assert property (@(posedge clk_in) disable iff (hard_rst)
		(state_reg == arpd_pkg::ARPD_DOWN && !pd_any) |=> !sample_ready_pulse_out [*2])
		else $error("ready pulse before filter settled");
	AST_SETTLE_END: assert property (@(posedge clk_in) disable iff (hard_rst)
		(state_reg == arpd_pkg::ARPD_SETTLE && settle_done && !pd_any && !full_req)
		|=> state_reg == arpd_pkg::ARPD_RUN)
		else $error("settle did not end on count");
	AST_CFG_KEPT: assert property (@(posedge clk_in) disable iff (hard_rst)
		!cfg_write_ok |=> $stable(cfg_reg))
		else $error("configuration changed without a write");
	AST_PHASE_KEPT: assert property (@(posedge clk_in) disable iff (hard_rst)
		!(phase_we_in && !two_wire_mode_in) |=> $stable(phase_reg))
		else $error("phase delay changed without a write");
	AST_DOWN_QUIET: assert property (@(posedge clk_in) disable iff (hard_rst)
		(pd_any && $past(pd_any)) |=> data_out == '0 && !sample_ready_pulse_out)
		else $error("output active in shutdown");
	AST_CLOCK_GATED: assert property (@(posedge clk_in) disable iff (hard_rst)
		pd_any |=> !power_out.core_clk_en && !power_out.input_clk_en)
		else $error("clock not gated in shutdown");
	AST_FULL_OFF: assert property (@(posedge clk_in) disable iff (hard_rst)
		full_req |=> !power_out.supply_mon_en && !power_out.clk_prop_en)
		else $error("full shutdown left logic enabled");
	AST_MON_BACK: assert property (@(posedge clk_in) disable iff (hard_rst)
		$fell(full_req) |=> power_out.supply_mon_en)
		else $error("supply monitors not re-enabled");
	AST_SERIAL_LIVE: assert property (@(posedge clk_in) disable iff (hard_rst)
		full_req |=> !serial_reset_out)
		else $error("serial interface stopped in full shutdown");
	AST_EXIT_SETTLE: assert property (@(posedge clk_in) disable iff (hard_rst)
		s_exit_down |-> state_reg == arpd_pkg::ARPD_SETTLE)
		else $error("shutdown exit skipped settling");

	// Reset values of state and enables, whatever the configuration was
	AST_POWER_RESET: assert property (@(posedge clk_in)
		hard_rst |=> power_out == '1 && phase_reg == arpd_pkg::PHASE_RESET
			&& state_reg == arpd_pkg::ARPD_RUN)
		else $error("hard reset left state or enables at wrong value");

	// Enables follow the decoded field directly, so settling never delays them
	AST_MON_ON: assert property (@(posedge clk_in) disable iff (hard_rst)
		!full_req |=> power_out.supply_mon_en)
		else $error("supply monitors off outside full shutdown");
	AST_BIAS_BACK: assert property (@(posedge clk_in) disable iff (hard_rst)
		!pd_any |=> power_out.bias_en && power_out.core_clk_en && power_out.input_clk_en)
		else $error("bias or clocks off with field clear");
	AST_VREF_FULL: assert property (@(posedge clk_in) disable iff (hard_rst)
		state_reg == arpd_pkg::ARPD_FULL |-> !power_out.vref_en)
		else $error("reference enabled in full shutdown");
	AST_TW_REFUSED: assert property (@(posedge clk_in) disable iff (hard_rst)
		(cfg_we_in && two_wire_mode_in) |=> $stable(cfg_reg))
		else $error("configuration written in two-wire mode");
endmodule

`default_nettype wire

// *** arpd_host_model.sv ***
// Host-side model issuing configuration and phase-delay writes
`timescale 1ns/1ns
`default_nettype none
module arpd_host_model (
	input wire logic clk_in, // Master clock
	input wire logic go_in, // Bench asks for one write
	input wire logic kind_in, // Low: configuration, high: phase delay
	input wire logic [7:0] word_in, // Write value
	input wire logic hard_reset_in, // Device hard reset
	output logic cfg_we_out, // Configuration strobe
	output var arpd_pkg::arpd_cfg_t cfg_out, // Configuration value
	output logic phase_we_out, // Phase-delay strobe
	output logic [7:0] phase_out // Phase-delay value
);
	// One-cycle strobes; a request in hard reset is dropped, not queued
	always_ff @(posedge clk_in) begin
		cfg_we_out <= go_in && !kind_in && !hard_reset_in;
		phase_we_out <= go_in && kind_in && !hard_reset_in;
		cfg_out <= arpd_pkg::arpd_cfg_t'(word_in[3:0]);
		phase_out <= word_in;
	end
endmodule
`default_nettype wire

// *** arpd_ctrl_tb.sv ***
// Testbench for the converter reset and power-down controller
`timescale 1ns/1ns
`default_nettype none
module arpd_ctrl_tb;
	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic reset_n_in = 1'b1;
	logic two_wire_mode_in = 1'b0;
	logic go = 1'b0;
	logic kind = 1'b0;
	logic [7:0] word = 8'h00;
	logic sample_in = 1'b0;
	logic [23:0] sdat = 24'h000000;
	logic cfg_we, phase_we, hrst, srl_rst, fclr, cf_en, pulse;
	logic [3:0] cf;
	logic [7:0] ph_w, ph;
	logic [23:0] data_out;
	arpd_pkg::arpd_cfg_t cfg_w, cfg_out;
	arpd_pkg::arpd_power_t pw;
	localparam int TB_SETTLE = 4;
	int failures = 0;
	int n_checks = 0;
	int n;
	// Row: {config, bias_en, supply_mon_en, clk_prop_en}
	logic [6:0] rows [8] = '{7'h07, 7'h23, 7'h43, 7'h63, 7'h38, 7'h78, 7'h5B, 7'h1F};
	initial begin
		forever #5 clk_in = ~clk_in;
	end
	arpd_host_model host (.clk_in(clk_in), .go_in(go), .kind_in(kind), .word_in(word),
		.hard_reset_in(hrst), .cfg_we_out(cfg_we), .cfg_out(cfg_w), .phase_we_out(phase_we),
		.phase_out(ph_w));
	// Short settle count keeps the run brief
	arpd_ctrl #(.SETTLE_CYC(TB_SETTLE)) dut (.clk_in(clk_in), .srst_in(srst_in),
		.reset_n_in(reset_n_in),
		.two_wire_mode_in(two_wire_mode_in), .cfg_we_in(cfg_we), .cfg_in(cfg_w),
		.phase_delay_in(ph_w), .phase_we_in(phase_we), .sample_in(sample_in),
		.sample_data_in(sdat), .hard_reset_out(hrst), .serial_reset_out(srl_rst),
		.filter_clear_out(fclr), .comp_force_out(cf), .comp_force_en_out(cf_en),
		.cfg_out(cfg_out), .phase_delay_out(ph), .power_out(pw), .data_out(data_out),
		.sample_ready_pulse_out(pulse));
	task automatic tick(input int c);
		repeat (c) @(posedge clk_in);
		#1;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic k, input logic [7:0] w);
		tick(1);
		go = 1'b1;
		kind = k;
		word = w;
		tick(1);
		go = 1'b0;
	endtask
	// One sample; pulse and data are looked at in the cycle after it is taken
	task automatic smp(input logic [23:0] d);
		sample_in = 1'b1;
		sdat = d;
		tick(1);
		sample_in = 1'b0;
	endtask
	task automatic wrap_up;
		if (failures == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		tick(3);
		chk("rst_power", 32'h3F, pw);
		srst_in = 1'b0;
		tick(2);
		// Eight of the sixteen configuration codes, each held until the state has settled
		for (int i = 0; i < 8; i++) begin
			wr(1'b0, {4'h0, rows[i][6:3]});
			tick(10);
			chk("cfg", rows[i][6:3], cfg_out);
			chk("bias", rows[i][2], pw.bias_en);
			chk("core_clk", rows[i][2], pw.core_clk_en);
			chk("supmon", rows[i][1], pw.supply_mon_en);
			chk("clkprop", rows[i][0], pw.clk_prop_en);
			chk("input_clk", rows[i][2], pw.input_clk_en);
			chk("vref", rows[i][0], pw.vref_en);
			chk("fclr_run", !rows[i][2], fclr);
			chk("srl_live", 0, srl_rst);
			smp(24'hA50000 + 24'(i));
			chk("pulse", rows[i][2], pulse);
			chk("data", rows[i][2] ? 24'hA50000 + 24'(i) : 24'h0, data_out);
		end
		// Phase delay kept across shutdown; first ready only after settling
		wr(1'b1, 8'h5A);
		wr(1'b0, 8'h04);
		tick(4);
		wr(1'b0, 8'h00);
		// Sample held high; bench counts edges until the first ready pulse
		n = 0;
		sample_in = 1'b1;
		sdat = 24'h123456;
		while (n < 20 && pulse !== 1'b1) begin
			tick(1);
			n++;
		end
		sample_in = 1'b0;
		chk("settle_n", TB_SETTLE + 2, n);
		chk("settle_data", 24'h123456, data_out);
		chk("phase", 8'h5A, ph);
		// Two-wire mode: pin ignored, configuration writes refused
		two_wire_mode_in = 1'b1;
		reset_n_in = 1'b0;
		wr(1'b0, 8'h07);
		tick(3);
		chk("tw_hrst", 0, hrst);
		chk("tw_cfg", 4'h0, cfg_out);
		// Pin reset in serial mode
		two_wire_mode_in = 1'b0;
		tick(2);
		chk("hrst", 1, hrst);
		chk("srl_rst", 1, srl_rst);
		chk("fclr", 1, fclr);
		chk("cmp", 5'h13, {cf_en, cf});
		wr(1'b0, 8'h07);
		smp(24'h777777);
		chk("rst_data", 25'h0, {pulse, data_out});
		reset_n_in = 1'b1;
		tick(2);
		chk("rst_phase", 9'h000, {hrst, ph});
		chk("rst_cfg", 4'h0, cfg_out);
		wr(1'b0, 8'h04);
		tick(2);
		chk("post_rst_cfg", 4'h4, cfg_out);
		wrap_up();
	end
endmodule
`default_nettype wire
